// [pwig_pkg.sv]
// Package of timing constants and encodings for the peripheral wait and acknowledge glue
package pwig_pkg;
   // ==========================================================================
   // Clock
   // ==========================================================================
   localparam int CLK_PERIOD_NS = 40;

   // ==========================================================================
   // Peripheral selects
   // ==========================================================================
   typedef enum logic [2:0] {
      PWIG_SEL_NONE,
      PWIG_SEL_SERIAL,
      PWIG_SEL_PARALLEL,
      PWIG_SEL_INTCTL,
      PWIG_SEL_POLLCTL,
      PWIG_SEL_MODULE
   } pwig_sel_t;

   // ==========================================================================
   // Wait states and recovery times
   // ==========================================================================
   localparam logic [3:0] SERIAL_WAITS = 4'h2;
   localparam logic [3:0] PARALLEL_WAITS = 4'h2;
   localparam logic [3:0] INTCTL_WAITS = 4'h1;
   localparam logic [3:0] ACK_WAITS = 4'h1;
   localparam logic [3:0] SERIAL_CMD_DELAY = 4'h4;
   localparam logic [3:0] TRANSCEIVER_HOLDOFF = 4'h3;

   localparam int WRITE_RECOVERY_MIN_NS = 300;
   localparam int ACCESS_CYCLE_MIN_NS = 850;
   localparam int COMMAND_TO_COMMAND_MIN_NS = 500;
   localparam int WRITE_TO_WRITE_MIN_NS = 190;
   localparam int READ_TO_READ_MIN_NS = 160;

   // Least times round up to whole cycles
   function automatic logic [7:0] pwig_ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[7:0];
   endfunction

   localparam logic [7:0] WRITE_RECOVERY_CYC = pwig_ns_to_cyc(WRITE_RECOVERY_MIN_NS);
   localparam logic [7:0] ACCESS_CYCLE_CYC = pwig_ns_to_cyc(ACCESS_CYCLE_MIN_NS);
   localparam logic [7:0] CMD_TO_CMD_CYC = pwig_ns_to_cyc(COMMAND_TO_COMMAND_MIN_NS);
   localparam logic [7:0] WRITE_TO_WRITE_CYC = pwig_ns_to_cyc(WRITE_TO_WRITE_MIN_NS);
   localparam logic [7:0] READ_TO_READ_CYC = pwig_ns_to_cyc(READ_TO_READ_MIN_NS);

   // Three idle cycles between the two acknowledge cycles
   localparam logic [3:0] ACK_IDLE_CYC = 4'h3;
   localparam logic [2:0] CASCADE_LSB = 3'h0;
endpackage

// [pwig_glue.sv]
// Ready, command spacing and interrupt acknowledge glue for byte-wide peripherals
`timescale 1ns/1ps
module pwig_glue #(
   parameter int CAS_W = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Bus controller side
   input wire logic addr_latch_strobe_i,
   input wire pwig_pkg::pwig_sel_t sel_i,
   input wire logic rd_cmd_i,
   input wire logic wr_cmd_i,
   input wire logic interrupt_acknowledge_i,
   input wire logic master_cascade_enable_i,
   // Cascade address from the master controller
   input wire logic [CAS_W-1:0] cascade_addr_i,
   // Expansion module pins
   input wire logic module_wait_request_i,
   input wire logic module_present_i,
   // Outputs to the processor side
   output logic ready_o,
   output logic command_delay_o,
   output logic async_ready_input_o,
   output logic transceiver_en_o,
   output logic [CAS_W-1:0] cascade_latched_o,
   output logic ack_second_o,
   output logic module_detected_o,
   output logic module_sel_block_o,
   output logic poll_pending_o
);
   import pwig_pkg::*;

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic wait_req_s1, wait_req_s2, present_s1, present_s2;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wait_req_s1 <= 1'b0;
         wait_req_s2 <= 1'b0;
         present_s1 <= 1'b0;
         present_s2 <= 1'b0;
      end else begin
         wait_req_s1 <= module_wait_request_i;
         wait_req_s2 <= wait_req_s1;
         present_s1 <= module_present_i;
         present_s2 <= present_s1;
      end
   end

   // ==========================================================================
   // Select latch and command edges
   // ==========================================================================
   pwig_sel_t sel_lat;
   logic cmd_any, cmd_prev, ack_prev;
   logic cmd_rise, cmd_fall, ack_rise;
   assign cmd_any = rd_cmd_i | wr_cmd_i | interrupt_acknowledge_i;
   assign cmd_rise = cmd_any & ~cmd_prev;
   assign cmd_fall = ~cmd_any & cmd_prev;
   assign ack_rise = interrupt_acknowledge_i & ~ack_prev;

   // Latched chip select decides the wait count for the cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sel_lat <= PWIG_SEL_NONE;
      end else if (addr_latch_strobe_i) begin
         sel_lat <= sel_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cmd_prev <= 1'b0;
         ack_prev <= 1'b0;
      end else begin
         cmd_prev <= cmd_any;
         ack_prev <= interrupt_acknowledge_i;
      end
   end

   function automatic logic [3:0] pwig_waits(input pwig_sel_t s, input logic ack);
      logic [3:0] w;
      w = 4'h0;
      if (ack) begin
         w = ACK_WAITS;
      end else begin
         unique case (s)
            PWIG_SEL_SERIAL: w = SERIAL_WAITS;
            PWIG_SEL_PARALLEL: w = PARALLEL_WAITS;
            PWIG_SEL_INTCTL: w = INTCTL_WAITS;
            PWIG_SEL_POLLCTL: w = INTCTL_WAITS;
            PWIG_SEL_MODULE: w = 4'h0;
            PWIG_SEL_NONE: w = 4'h0;
         endcase
      end
      return w;
   endfunction

   // ==========================================================================
   // Command spacing: one shared counter since the last command end, applied only when the target repeats
   // ==========================================================================
   logic [7:0] gap_cnt;
   logic [7:0] gap_need;
   logic last_wr;
   logic wr_cmd_q;
   pwig_sel_t last_sel;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         gap_cnt <= 8'hff;
         last_wr <= 1'b0;
         last_sel <= PWIG_SEL_NONE;
      end else if (cmd_fall) begin
         gap_cnt <= 8'h0;
         last_wr <= wr_cmd_q;
         last_sel <= sel_lat;
      end else if (gap_cnt != 8'hff) begin
         gap_cnt <= gap_cnt + 8'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_cmd_q <= 1'b0;
      end else if (cmd_any) begin
         wr_cmd_q <= wr_cmd_i;
      end
   end

   always_comb begin
      gap_need = 8'h0;
      if (last_sel == sel_lat) begin
         unique case (sel_lat)
            PWIG_SEL_SERIAL: gap_need = (last_wr && wr_cmd_i) ? WRITE_RECOVERY_CYC : 8'h0;
            PWIG_SEL_PARALLEL: gap_need = ACCESS_CYCLE_CYC;
            PWIG_SEL_INTCTL, PWIG_SEL_POLLCTL: begin
               // Hardware spacing used even though software spacing also suffices
               if (last_wr != wr_cmd_i) begin
                  gap_need = CMD_TO_CMD_CYC;
               end else if (wr_cmd_i) begin
                  gap_need = WRITE_TO_WRITE_CYC;
               end else begin
                  gap_need = READ_TO_READ_CYC;
               end
            end
            PWIG_SEL_MODULE: gap_need = 8'h0;
            PWIG_SEL_NONE: gap_need = 8'h0;
         endcase
      end
   end

   // ==========================================================================
   // Cycle sequencer: delay, waits, ready
   // ==========================================================================
   typedef enum {PWIG_IDLE, PWIG_DELAY, PWIG_WAIT, PWIG_DONE} pwig_state_t;
   pwig_state_t state;
   logic [3:0] wait_cnt;
   logic [3:0] dly_cnt;
   logic spacing_ok;
   assign spacing_ok = (gap_cnt >= gap_need);

   // Command is held off while the fixed delay or, for non-acknowledge commands, the spacing still runs
   logic cmd_hold;
   logic serial_wr;
   assign cmd_hold = (dly_cnt != 4'h0) || !(spacing_ok || interrupt_acknowledge_i);
   assign serial_wr = (sel_lat == PWIG_SEL_SERIAL) && wr_cmd_i;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= PWIG_IDLE;
         wait_cnt <= 4'h0;
         dly_cnt <= 4'h0;
      end else begin
         unique case (state)
            PWIG_IDLE: begin
               if (cmd_rise) begin
                  wait_cnt <= pwig_waits(sel_lat, interrupt_acknowledge_i);
                  // Serial writes carry a fixed four-cycle command delay
                  dly_cnt <= (sel_lat == PWIG_SEL_SERIAL && wr_cmd_i) ?
                             SERIAL_CMD_DELAY : 4'h0;
                  state <= PWIG_DELAY;
               end
            end
            PWIG_DELAY: begin
               if (dly_cnt != 4'h0) begin
                  dly_cnt <= dly_cnt - 4'h1;
               end else if (spacing_ok || interrupt_acknowledge_i) begin
                  state <= PWIG_WAIT;
               end
            end
            PWIG_WAIT: begin
               if (wait_cnt != 4'h0) begin
                  wait_cnt <= wait_cnt - 4'h1;
               end else if (!wait_req_s2) begin
                  // A module wait request keeps the cycle open here
                  state <= PWIG_DONE;
               end
            end
            PWIG_DONE: begin
               if (!cmd_any) begin
                  state <= PWIG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ready_o <= 1'b0;
         command_delay_o <= 1'b0;
      end else begin
         ready_o <= (state == PWIG_WAIT) && (wait_cnt == 4'h0) && !wait_req_s2;
         // Flag only real hold-off, so acknowledges and reads whose spacing is met show no delay
         command_delay_o <= (state == PWIG_IDLE && cmd_rise && serial_wr) ||
                            (state == PWIG_DELAY && cmd_hold);
      end
   end

   // Inverted module wait stretches the cycle through the async ready path
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         async_ready_input_o <= 1'b1;
      end else begin
         async_ready_input_o <= ~wait_req_s2;
      end
   end

   // ==========================================================================
   // Data transceiver hold-off after parallel port reads
   // ==========================================================================
   logic [3:0] float_cnt;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         float_cnt <= 4'h0;
      end else if (cmd_fall && sel_lat == PWIG_SEL_PARALLEL && !wr_cmd_q) begin
         float_cnt <= TRANSCEIVER_HOLDOFF;
      end else if (float_cnt != 4'h0) begin
         float_cnt <= float_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         transceiver_en_o <= 1'b0;
      end else begin
         transceiver_en_o <= cmd_any && (float_cnt == 4'h0);
      end
   end

   // ==========================================================================
   // Interrupt acknowledge pairing and cascade latch
   // ==========================================================================
   // First acknowledge of a pair sets the flag and the second clears it; processor spaces the pair itself
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack_second_o <= 1'b0;
      end else if (ack_rise) begin
         ack_second_o <= ~ack_second_o;
      end
   end

   // Cascade address picks the one slave allowed to drive the vector
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cascade_latched_o <= '0;
      end else if (addr_latch_strobe_i && master_cascade_enable_i) begin
         cascade_latched_o <= cascade_addr_i;
      end
   end

   // ==========================================================================
   // Third-level poll tracking and module presence
   // ==========================================================================
   // Poll write must be followed by a read of the same controller
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         poll_pending_o <= 1'b0;
      end else if (cmd_rise && sel_lat == PWIG_SEL_POLLCTL) begin
         poll_pending_o <= wr_cmd_i;
      end else if (cmd_rise) begin
         poll_pending_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         module_detected_o <= 1'b0;
         module_sel_block_o <= 1'b1;
      end else begin
         module_detected_o <= present_s2;
         module_sel_block_o <= ~present_s2;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   AST_SERIAL_DELAY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == PWIG_IDLE && cmd_rise && sel_lat == PWIG_SEL_SERIAL && wr_cmd_i)
      |-> ##1 command_delay_o[*4])
      else $error("Serial write command delay too short");
   AST_READY_AFTER_WAITS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(ready_o) |-> $past(state == PWIG_WAIT))
      else $error("Ready raised outside wait phase");
   AST_ASYNC_INV: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 async_ready_input_o == !$past(wait_req_s2))
      else $error("Async ready is not the inverted wait request");
   AST_NO_READY_IN_WAIT_REQ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wait_req_s2 |=> !ready_o)
      else $error("Ready given while module requests wait");
   AST_PARALLEL_FLOAT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cmd_fall && sel_lat == PWIG_SEL_PARALLEL && !wr_cmd_q) |=> ##1 !transceiver_en_o[*2])
      else $error("Transceiver enabled during parallel data float");
   AST_CASCADE_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(addr_latch_strobe_i && master_cascade_enable_i) |=> $stable(cascade_latched_o))
      else $error("Cascade address changed without enable and strobe");
   AST_ACK_TOGGLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ack_rise |=> ack_second_o != $past(ack_second_o))
      else $error("Acknowledge pairing did not advance");
   AST_MODULE_STRETCH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == PWIG_WAIT && wait_req_s2) |=> (state == PWIG_WAIT))
      else $error("Cycle ended while module requests wait");
   AST_ACK_NO_DELAY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == PWIG_IDLE && cmd_rise && interrupt_acknowledge_i) |=> ##1 (state == PWIG_WAIT))
      else $error("Acknowledge cycle was delayed");
   AST_MODULE_BLOCK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      module_sel_block_o != module_detected_o)
      else $error("Module select block disagrees with presence");
endmodule

// [pwig_far_model.sv]
// Far side model: cascaded interrupt controllers and expansion module pins
`timescale 1ns/1ps
module pwig_far_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Bus side
   input wire logic ack_i,
   input wire logic cas_en_i,
   input wire logic mod_start_i,
   // Scenario knobs
   input wire logic [7:0] irq_i,
   input wire logic [3:0] stall_i,
   input wire logic present_i,
   // Pins towards the glue
   output logic [2:0] cas_o,
   output logic wait_o,
   output logic present_o
);
   logic [7:0] frozen;
   logic [2:0] win;
   logic [2:0] last_cas;
   logic [3:0] left;
   logic ack_d;
   logic in_pair;
   // ==========================================
   // Interrupt controllers
   always_ff @(posedge clk_i) begin
      ack_d <= ack_i;
      in_pair <= sys_rst_i ? 1'h0 : in_pair ^ (ack_i & ~ack_d);
      if (!in_pair && !ack_i) begin
         frozen <= irq_i;
      end
      if (sys_rst_i) begin
         last_cas <= 3'h0;
      end else if (cas_en_i) begin
         last_cas <= win;
      end
   end
   always_comb begin
      win = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (frozen[i]) win = 3'(i);
      end
   end
   // Released lines show the inverse, so a stale copy cannot pass for a match
   assign cas_o = cas_en_i ? win : ~last_cas;
   // ==========================================
   // Expansion module
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         left <= 4'h0;
      end else if (mod_start_i) begin
         left <= stall_i;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign wait_o = (left != 4'h0);
   assign present_o = present_i;
endmodule

// [testbench.sv]
// Self-checking bench for the peripheral wait and acknowledge glue
`timescale 1ns/1ps
module testbench;
   import pwig_pkg::*;
   // ==========================================
   // Signals
   logic clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic addr_latch_strobe_i = 1'h0;
   pwig_sel_t sel_i = PWIG_SEL_NONE;
   logic rd_cmd_i = 1'h0;
   logic wr_cmd_i = 1'h0;
   logic ack_i = 1'h0;
   logic cas_en = 1'h0;
   logic [7:0] irq = 8'h00;
   logic [3:0] stall = 4'h0;
   logic present = 1'h0;
   logic [2:0] cas;
   logic mod_wait, mpres, ready_o, command_delay_o, async_ready_input_o, transceiver_en_o;
   logic [2:0] cascade_latched_o;
   logic ack_second_o, module_detected_o, module_sel_block_o, poll_pending_o;
   int xcvr_off = 0;
   int errors = 0;
   int cmp_count = 0;
   always #20 clk_i = ~clk_i;
   pwig_glue #(.CAS_W(3)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .addr_latch_strobe_i(addr_latch_strobe_i), .sel_i(sel_i), .rd_cmd_i(rd_cmd_i),
      .wr_cmd_i(wr_cmd_i), .interrupt_acknowledge_i(ack_i), .master_cascade_enable_i(cas_en),
      .cascade_addr_i(cas), .module_wait_request_i(mod_wait), .module_present_i(mpres),
      .ready_o(ready_o), .command_delay_o(command_delay_o),
      .async_ready_input_o(async_ready_input_o), .transceiver_en_o(transceiver_en_o),
      .cascade_latched_o(cascade_latched_o), .ack_second_o(ack_second_o),
      .module_detected_o(module_detected_o), .module_sel_block_o(module_sel_block_o),
      .poll_pending_o(poll_pending_o));
   pwig_far_model far_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ack_i(ack_i), .cas_en_i(cas_en),
      .mod_start_i(addr_latch_strobe_i && (sel_i == PWIG_SEL_MODULE)), .irq_i(irq),
      .stall_i(stall), .present_i(present), .cas_o(cas), .wait_o(mod_wait), .present_o(mpres));
   // ==========================================
   // Common tasks
   task automatic stop_test();
      $display("Comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   // One bus cycle: strobe, then the command held until ready is sampled high
   task automatic acc(input pwig_sel_t s, input logic w, input logic a, input logic m,
                      input int idle, output int lat, output logic dly, output logic lo);
      repeat (idle) @(posedge clk_i);
      @(posedge clk_i);
      addr_latch_strobe_i <= 1'h1;
      sel_i <= s;
      cas_en <= m;
      @(posedge clk_i);
      addr_latch_strobe_i <= 1'h0;
      cas_en <= 1'h0;
      rd_cmd_i <= !w && !a;
      wr_cmd_i <= w;
      ack_i <= a;
      lat = 0;
      dly = 1'h0;
      lo = 1'h0;
      xcvr_off = 0;
      while (ready_o !== 1'h1) begin
         @(posedge clk_i);
         lat++;
         if (command_delay_o === 1'h1) dly = 1'h1;
         if (async_ready_input_o === 1'h0) lo = 1'h1;
         if (transceiver_en_o === 1'h0) xcvr_off++;
         if (lat > 200) begin
            check("ready timeout", 32'h0, 32'h1);
            stop_test();
         end
      end
      rd_cmd_i <= 1'h0;
      wr_cmd_i <= 1'h0;
      ack_i <= 1'h0;
   endtask
   // ==========================================
   // Scenarios
   task automatic sc_reset();
      repeat (4) @(posedge clk_i);
      check("reset outputs", 32'({ready_o, command_delay_o, async_ready_input_o,
         module_sel_block_o, module_detected_o, poll_pending_o, ack_second_o}),
         32'h18);
   endtask
   task automatic sc_waits();
      int ls, lp, li, lw;
      logic d0, d1, d2, lo;
      acc(PWIG_SEL_SERIAL, 1'h0, 1'h0, 1'h0, 30, ls, d0, lo);
      check("xcvr prompt", 32'(xcvr_off), 32'h1);
      acc(PWIG_SEL_PARALLEL, 1'h0, 1'h0, 1'h0, 30, lp, d1, lo);
      // Right after a parallel read the transceivers must stay off longer
      acc(PWIG_SEL_INTCTL, 1'h0, 1'h0, 1'h0, 0, li, d2, lo);
      check("xcvr held", 32'(xcvr_off > 1), 32'h1);
      check("par less intctl", 32'(lp - li), 32'(PARALLEL_WAITS - INTCTL_WAITS));
      check("serial read", 32'(ls), 32'(lp));
      check("read delay", 32'({d0, d1, d2}), 32'h0);
      acc(PWIG_SEL_SERIAL, 1'h1, 1'h0, 1'h0, 30, lw, d0, lo);
      check("serial write extra", 32'(lw - ls), 32'(SERIAL_CMD_DELAY));
      check("serial write held", 32'(d0), 32'h1);
   endtask
   task automatic sc_spacing();
      int a, b;
      logic d, lo;
      acc(PWIG_SEL_PARALLEL, 1'h0, 1'h0, 1'h0, 30, a, d, lo);
      acc(PWIG_SEL_PARALLEL, 1'h1, 1'h0, 1'h0, 0, b, d, lo);
      check("parallel spacing", 32'(a + 2 + b >= ACCESS_CYCLE_CYC), 32'h1);
      acc(PWIG_SEL_INTCTL, 1'h1, 1'h0, 1'h0, 30, a, d, lo);
      acc(PWIG_SEL_INTCTL, 1'h1, 1'h0, 1'h0, 0, b, d, lo);
      check("intctl spacing", 32'(a + 2 + b >= CMD_TO_CMD_CYC), 32'h1);
      acc(PWIG_SEL_SERIAL, 1'h1, 1'h0, 1'h0, 30, a, d, lo);
      acc(PWIG_SEL_SERIAL, 1'h1, 1'h0, 1'h0, 0, b, d, lo);
      check("serial recovery", 32'(b > a), 32'h1);
   endtask
   task automatic sc_interrupt_acknowledge();
      int r, a, b;
      logic d0, d1, lo;
      irq <= 8'h28;
      acc(PWIG_SEL_INTCTL, 1'h0, 1'h0, 1'h0, 30, r, d0, lo);
      acc(PWIG_SEL_NONE, 1'h0, 1'h1, 1'h1, 30, a, d0, lo);
      check("first ack", 32'(ack_second_o), 32'h1);
      irq <= 8'h02;
      // One idle edge plus the strobe cycle gives three idle states
      acc(PWIG_SEL_NONE, 1'h0, 1'h1, 1'h0, 1, b, d1, lo);
      check("second ack", 32'(ack_second_o), 32'h0);
      check("ack waits", {a[15:0], b[15:0]}, {r[15:0], r[15:0]});
      check("ack delay", 32'({d0, d1}), 32'h0);
      check("cascade", 32'(cascade_latched_o), 32'h3);
      irq <= 8'h00;
   endtask
   task automatic sc_poll();
      int a;
      logic d, lo;
      acc(PWIG_SEL_POLLCTL, 1'h1, 1'h0, 1'h0, 30, a, d, lo);
      @(posedge clk_i);
      check("poll armed", 32'(poll_pending_o), 32'h1);
      acc(PWIG_SEL_POLLCTL, 1'h0, 1'h0, 1'h0, 0, a, d, lo);
      @(posedge clk_i);
      check("poll cleared", 32'(poll_pending_o), 32'h0);
   endtask
   task automatic sc_module();
      int a, b;
      logic d, lo;
      present <= 1'h1;
      repeat (4) @(posedge clk_i);
      check("present", 32'({module_detected_o, module_sel_block_o}), 32'h2);
      stall <= 4'h8;
      acc(PWIG_SEL_MODULE, 1'h0, 1'h0, 1'h0, 30, a, d, lo);
      check("ready pin low", 32'(lo), 32'h1);
      check("stretched", 32'(a >= 8), 32'h1);
      stall <= 4'h0;
      acc(PWIG_SEL_MODULE, 1'h0, 1'h0, 1'h0, 30, b, d, lo);
      check("prompt", 32'({lo, 1'(b < a)}), 32'h1);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      sc_reset();
      sc_waits();
      sc_spacing();
      sc_interrupt_acknowledge();
      sc_poll();
      sc_module();
      stop_test();
   end
endmodule
